// ===== ck_master.sv
`timescale 1ns/100ps
`default_nettype none
module ck_master (
    // Data line level
    input wire logic dataLine,
    // Master pins
    output logic     ck,
    output logic     mData
);
    // Clock idles low between frames
    initial begin
        ck = 1'b0;
        mData = 1'b0;
    end
    // One frame; a released line toggles every bit
    task automatic frame(input int n, input logic drive, input logic [8:0] txBits, output logic [8:0] got);
        got = 9'h000;
        for (int i = 0; i < n; i++) begin
            mData = drive ? txBits[i] : ~mData;
            #40 ck = 1'b1;
            #80 ck = 1'b0;
            got[i] = dataLine;
            #40;
        end
        mData = ~mData;
    endtask : frame
endmodule : ck_master
`default_nettype wire

// ===== test_usart_sync_slave.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_usart_sync_slave;
    logic        clk_sys, reset_n, clockSourceSelect, syncSelect, portEnable;
    logic        transmitEnable, transmitNinthEnable, transmitNinthValue;
    logic        continuousReceiveEnable, singleReceiveEnable, receiveNinthEnable;
    logic        transmitIrqEnable, receiveIrqEnable, globalIrqEnable;
    logic        txWrite, rxRead, rxNinthBit, overrunError, transmitEmptyFlag;
    logic        receiveFullFlag, wakeUp, irqTake, shiftClockIn, shiftClockOut;
    logic        shiftClockOe_n, dataIn, dataOut, dataOe_n, ck, mData;
    logic [7:0]  txWriteData, rxData;
    logic [13:0] irqVectorAddr;
    logic [8:0]  got;
    int          seed, n_mismatch, check_count, cycles, w, v, txQ[$];
    // Pin levels from all drivers
    assign shiftClockIn = shiftClockOe_n ? ck : shiftClockOut;
    assign dataIn = dataOe_n ? mData : dataOut;
    usart_sync_slave u_usart_sync_slave (.*);
    ck_master u_ck_master (.dataLine(dataIn), .ck(ck), .mData(mData));
    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Holding register write, model queue keeps the frame
    task automatic wr(input logic [7:0] d);
        @(negedge clk_sys);
        txWrite = 1'b1;
        txWriteData = d;
        txQ.push_back({transmitNinthValue, d});
        @(negedge clk_sys);
        txWrite = 1'b0;
    endtask : wr
    // Master sends a random word
    task automatic rxWord(input int n, output int r);
        r = $random(seed) & ((1 << n) - 1);
        u_ck_master.frame(n, 1'b1, r[8:0], got);
        repeat (10) @(negedge clk_sys);
    endtask : rxWord
    // Main sequence
    initial begin
        seed = 44190;
        {clockSourceSelect, transmitNinthEnable, transmitNinthValue, continuousReceiveEnable} = '0;
        {singleReceiveEnable, receiveNinthEnable, transmitIrqEnable, receiveIrqEnable} = '0;
        {globalIrqEnable, txWrite, rxRead, reset_n} = '0;
        {syncSelect, portEnable, transmitEnable} = 3'b111;
        txWriteData = 8'h00;
        repeat (5) @(negedge clk_sys);
        `CHK({shiftClockOe_n, shiftClockOut, transmitEmptyFlag, receiveFullFlag, irqTake}, 5'b10100)
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Two queued words, plain and nine-bit
        for (int m = 0; m < 2; m++) begin
            transmitNinthEnable = m[0];
            transmitIrqEnable = 1'b1;
            globalIrqEnable = m[0];
            transmitNinthValue = $random(seed);
            w = $random(seed);
            wr(w[7:0]);
            repeat (3) @(negedge clk_sys);
            transmitNinthValue = $random(seed);
            w = $random(seed);
            wr(w[7:0]);
            `CHK({transmitEmptyFlag, wakeUp}, 2'b00)
            for (int k = 0; k < 2; k++) begin
                u_ck_master.frame(8 + m, 1'b0, 9'h000, got);
                w = txQ.pop_front() & (m ? 'h1ff : 'hff);
                `CHK(got, w[8:0])
                repeat (10) @(negedge clk_sys);
                `CHK({transmitEmptyFlag, dataOe_n, wakeUp}, {1'b1, k[0], 1'b1})
                `CHK(irqVectorAddr, m ? 14'h0004 : 14'h0000)
            end
        end
        // Reception, plain and nine-bit
        transmitIrqEnable = 1'b0;
        receiveIrqEnable = 1'b1;
        globalIrqEnable = 1'b1;
        continuousReceiveEnable = 1'b1;
        for (int m = 0; m < 2; m++) begin
            receiveNinthEnable = m[0];
            singleReceiveEnable = $random(seed);
            rxWord(8 + m, v);
            `CHK({receiveFullFlag, wakeUp, rxNinthBit, rxData}, {2'b11, v[8:0]})
            `CHK({irqVectorAddr, dataOe_n}, {14'h0004, 1'b1})
            rxRead = 1'b1;
            @(negedge clk_sys) rxRead = 1'b0;
            `CHK(receiveFullFlag, 1'b0)
        end
        // Overrun, then cleared by dropping receive enable
        receiveNinthEnable = 1'b0;
        rxWord(8, v);
        rxWord(8, w);
        `CHK({overrunError, rxData}, {1'b1, v[7:0]})
        continuousReceiveEnable = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(overrunError, 1'b0)
        // Clock source select set: port leaves slave mode and takes nothing
        rxRead = 1'b1;
        @(negedge clk_sys) rxRead = 1'b0;
        {clockSourceSelect, continuousReceiveEnable} = 2'b11;
        rxWord(8, v);
        `CHK({receiveFullFlag, dataOe_n}, 2'b01)
        end_of_test();
    end
endmodule : test_usart_sync_slave
`default_nettype wire

// ===== usart_sync_slave.sv
`timescale 1ns/100ps
`default_nettype none
module usart_sync_slave (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // Configuration bits
    input  wire logic                  clockSourceSelect,
    input  wire logic                  syncSelect,
    input  wire logic                  portEnable,
    input  wire logic                  transmitEnable,
    input  wire logic                  transmitNinthEnable,
    input  wire logic                  transmitNinthValue,
    input  wire logic                  continuousReceiveEnable,
    input  wire logic                  singleReceiveEnable,
    input  wire logic                  receiveNinthEnable,
    input  wire logic                  transmitIrqEnable,
    input  wire logic                  receiveIrqEnable,
    input  wire logic                  globalIrqEnable,
    // Transmit holding register write
    input  wire logic                  txWrite,
    input  wire logic [7:0]            txWriteData,
    // Receive holding register read
    input  wire logic                  rxRead,
    output logic      [7:0]            rxData,
    output logic                       rxNinthBit,
    output logic                       overrunError,
    // Status flags and wake-up
    output logic                       transmitEmptyFlag,
    output logic                       receiveFullFlag,
    output logic                       wakeUp,
    output logic                       irqTake,
    output logic      [13:0]           irqVectorAddr,
    // Shift clock pin
    input  wire logic                  shiftClockIn,
    output logic                       shiftClockOut,
    output logic                       shiftClockOe_n,
    // Data pin
    input  wire logic                  dataIn,
    output logic                       dataOut,
    output logic                       dataOe_n
);

    // Pin synchronisers and edge history
    logic        ckMeta_ff, ckSync_ff, ckLast_ff;
    logic        dinMeta_ff, dinSync_ff;
    logic        nxt_ckMeta, nxt_ckSync, nxt_ckLast;
    logic        nxt_dinMeta, nxt_dinSync;
    logic        ckRise, ckFall;
    logic        slaveOn, rxOn, txOn;

    // Transmit state
    usart_sync_slave_pkg::tx_state_e txState_ff, nxt_txState;
    logic [8:0]  txShift_ff, nxt_txShift;
    logic [8:0]  txHold_ff, nxt_txHold;
    logic        txHoldFull_ff, nxt_txHoldFull;
    logic [3:0]  txRemain_ff, nxt_txRemain;
    logic        dataOut_ff, nxt_dataOut;

    // Receive state
    logic [8:0]  rxShift_ff, nxt_rxShift;
    logic [3:0]  rxCount_ff, nxt_rxCount;
    logic [7:0]  rxData_ff, nxt_rxData;
    logic        rxNinth_ff, nxt_rxNinth;
    logic        rxFull_ff, nxt_rxFull;
    logic        overrun_ff, nxt_overrun;
    logic [8:0]  rxShifted;

    // Interrupt outputs
    logic        irqTake_ff, nxt_irqTake;
    logic [13:0] irqVector_ff, nxt_irqVector;

    // Two-flop synchronisers, edges taken from the second and third stage
    always_comb begin
        nxt_ckMeta  = shiftClockIn;
        nxt_ckSync  = ckMeta_ff;
        nxt_ckLast  = ckSync_ff;
        nxt_dinMeta = dataIn;
        nxt_dinSync = dinMeta_ff;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ckMeta_ff  <= 1'b0;
            ckSync_ff  <= 1'b0;
            ckLast_ff  <= 1'b0;
            dinMeta_ff <= 1'b0;
            dinSync_ff <= 1'b0;
        end else begin
            ckMeta_ff  <= nxt_ckMeta;
            ckSync_ff  <= nxt_ckSync;
            ckLast_ff  <= nxt_ckLast;
            dinMeta_ff <= nxt_dinMeta;
            dinSync_ff <= nxt_dinSync;
        end
    end

    // Mode decode and clock edges
    assign ckRise  = ckSync_ff & ~ckLast_ff;
    assign ckFall  = ~ckSync_ff & ckLast_ff;
    assign slaveOn = portEnable & syncSelect & ~clockSourceSelect;
    assign rxOn    = slaveOn & continuousReceiveEnable;
    assign txOn    = slaveOn & transmitEnable & ~continuousReceiveEnable;

    // Holding register, shifter and bit counter for transmit
    always_comb begin
        nxt_txState    = txState_ff;
        nxt_txShift    = txShift_ff;
        nxt_txHold     = txHold_ff;
        nxt_txHoldFull = txHoldFull_ff;
        nxt_txRemain   = txRemain_ff;
        nxt_dataOut    = dataOut_ff;
        if (txWrite) begin
            nxt_txHold     = {transmitNinthValue, txWriteData};
            nxt_txHoldFull = 1'b1;
        end
        if (!slaveOn || !transmitEnable) begin
            nxt_txState  = usart_sync_slave_pkg::TX_IDLE;
            nxt_txRemain = usart_sync_slave_pkg::CNT_ZERO;
        end else begin
            unique case (txState_ff)
                usart_sync_slave_pkg::TX_IDLE: begin
                    if (txHoldFull_ff) begin
                        nxt_txShift    = txHold_ff;
                        nxt_txHoldFull = txWrite;
                        nxt_txRemain   = usart_sync_slave_pkg::wordLength(transmitNinthEnable);
                        nxt_txState    = usart_sync_slave_pkg::TX_SHIFT;
                    end
                end
                usart_sync_slave_pkg::TX_SHIFT: begin
                    if (txOn && ckRise && txRemain_ff != usart_sync_slave_pkg::CNT_ZERO) begin
                        nxt_dataOut  = txShift_ff[0];
                        nxt_txShift  = {1'b0, txShift_ff[8:1]};
                        nxt_txRemain = txRemain_ff - usart_sync_slave_pkg::CNT_ONE;
                    end else if (txOn && ckFall && txRemain_ff == usart_sync_slave_pkg::CNT_ZERO) begin
                        if (txHoldFull_ff) begin
                            nxt_txShift    = txHold_ff;
                            nxt_txHoldFull = txWrite;
                            nxt_txRemain   = usart_sync_slave_pkg::wordLength(transmitNinthEnable);
                        end else begin
                            nxt_txState = usart_sync_slave_pkg::TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txState_ff    <= usart_sync_slave_pkg::TX_IDLE;
            txShift_ff    <= usart_sync_slave_pkg::SHIFT_RESET;
            txHold_ff     <= usart_sync_slave_pkg::SHIFT_RESET;
            txHoldFull_ff <= 1'b0;
            txRemain_ff   <= usart_sync_slave_pkg::CNT_ZERO;
            dataOut_ff    <= 1'b0;
        end else begin
            txState_ff    <= nxt_txState;
            txShift_ff    <= nxt_txShift;
            txHold_ff     <= nxt_txHold;
            txHoldFull_ff <= nxt_txHoldFull;
            txRemain_ff   <= nxt_txRemain;
            dataOut_ff    <= nxt_dataOut;
        end
    end

    // Receive shifter, holding register and error state
    assign rxShifted = {dinSync_ff, rxShift_ff[8:1]};

    always_comb begin
        nxt_rxShift  = rxShift_ff;
        nxt_rxCount  = rxCount_ff;
        nxt_rxData   = rxData_ff;
        nxt_rxNinth  = rxNinth_ff;
        nxt_rxFull   = rxFull_ff;
        nxt_overrun  = overrun_ff;
        if (rxRead) begin
            nxt_rxFull = 1'b0;
        end
        if (!continuousReceiveEnable || !slaveOn) begin
            nxt_overrun = 1'b0;
            nxt_rxCount = usart_sync_slave_pkg::CNT_ZERO;
        end else if (rxOn && !overrun_ff && ckFall) begin
            nxt_rxShift = rxShifted;
            nxt_rxCount = rxCount_ff + usart_sync_slave_pkg::CNT_ONE;
            if (nxt_rxCount == usart_sync_slave_pkg::wordLength(receiveNinthEnable)) begin
                nxt_rxCount = usart_sync_slave_pkg::CNT_ZERO;
                if (rxFull_ff && !rxRead) begin
                    nxt_overrun = 1'b1;
                end else begin
                    nxt_rxData  = receiveNinthEnable ? rxShifted[7:0] : rxShifted[8:1];
                    nxt_rxNinth = receiveNinthEnable & rxShifted[8];
                    nxt_rxFull  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxShift_ff <= usart_sync_slave_pkg::SHIFT_RESET;
            rxCount_ff <= usart_sync_slave_pkg::CNT_ZERO;
            rxData_ff  <= usart_sync_slave_pkg::DATA_RESET;
            rxNinth_ff <= 1'b0;
            rxFull_ff  <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            rxShift_ff <= nxt_rxShift;
            rxCount_ff <= nxt_rxCount;
            rxData_ff  <= nxt_rxData;
            rxNinth_ff <= nxt_rxNinth;
            rxFull_ff  <= nxt_rxFull;
            overrun_ff <= nxt_overrun;
        end
    end

    // Wake-up and vector request from the two flags
    always_comb begin
        nxt_irqTake   = wakeUp & globalIrqEnable;
        nxt_irqVector = nxt_irqTake ? usart_sync_slave_pkg::IRQ_VECTOR : usart_sync_slave_pkg::VEC_NONE;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqTake_ff   <= 1'b0;
            irqVector_ff <= usart_sync_slave_pkg::VEC_NONE;
        end else begin
            irqTake_ff   <= nxt_irqTake;
            irqVector_ff <= nxt_irqVector;
        end
    end

    // Outputs
    assign transmitEmptyFlag = ~txHoldFull_ff;
    assign receiveFullFlag   = rxFull_ff;
    assign wakeUp            = (~txHoldFull_ff & transmitIrqEnable) | (rxFull_ff & receiveIrqEnable);
    assign irqTake           = irqTake_ff;
    assign irqVectorAddr     = irqVector_ff;
    assign rxData            = rxData_ff;
    assign rxNinthBit        = rxNinth_ff;
    assign overrunError      = overrun_ff;
    assign shiftClockOut     = 1'b0;
    assign shiftClockOe_n    = 1'b1;
    assign dataOut           = dataOut_ff;
    assign dataOe_n          = ~(txOn && txState_ff == usart_sync_slave_pkg::TX_SHIFT);

    // Single-receive enable has no effect in slave mode
    logic unusedSingle;
    assign unusedSingle = singleReceiveEnable;

endmodule : usart_sync_slave
`default_nettype wire

// ===== usart_sync_slave_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module usart_sync_slave_monitor (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Controls
    input wire logic        txWrite,
    input wire logic        transmitEnable,
    input wire logic        continuousReceiveEnable,
    input wire logic        transmitIrqEnable,
    input wire logic        receiveIrqEnable,
    input wire logic        globalIrqEnable,
    // Flags and pins
    input wire logic        transmitEmptyFlag,
    input wire logic        receiveFullFlag,
    input wire logic        overrunError,
    input wire logic        wakeUp,
    input wire logic        irqTake,
    input wire logic [13:0] irqVectorAddr,
    input wire logic        dataOe_n,
    input wire logic        shiftClockOe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Write into an idle transmit path, then load into the shifter
    sequence s_idleWrite;
        txWrite && transmitEmptyFlag && dataOe_n && transmitEnable && !continuousReceiveEnable;
    endsequence
    sequence s_load;
        ##1 !transmitEmptyFlag ##[1:3] (!dataOe_n && transmitEmptyFlag);
    endsequence
    // Properties
    property p_clkFree; shiftClockOe_n; endproperty
    property p_emptyFall; txWrite |=> !transmitEmptyFlag; endproperty
    property p_load; s_idleWrite |-> s_load; endproperty
    property p_wake;
        wakeUp == ((transmitEmptyFlag && transmitIrqEnable) || (receiveFullFlag && receiveIrqEnable));
    endproperty
    property p_take; $past(reset_n) |-> irqTake == $past(wakeUp && globalIrqEnable); endproperty
    property p_vector;
        irqVectorAddr == (irqTake ? usart_sync_slave_pkg::IRQ_VECTOR : usart_sync_slave_pkg::VEC_NONE);
    endproperty
    property p_errClear; !continuousReceiveEnable |=> !overrunError; endproperty
    property p_errCause; $rose(overrunError) |-> $past(receiveFullFlag); endproperty
    a_clkFree: assert property (p_clkFree) else $error("shift clock driven");
    a_emptyFall: assert property (p_emptyFall) else $error("empty flag stayed set");
    a_load: assert property (p_load) else $error("write did not load shifter");
    a_wake: assert property (p_wake) else $error("wake request wrong");
    a_take: assert property (p_take) else $error("interrupt take wrong");
    a_vector: assert property (p_vector) else $error("vector address wrong");
    a_errClear: assert property (p_errClear) else $error("error not cleared");
    a_errCause: assert property (p_errCause) else $error("overrun without full");
endmodule : usart_sync_slave_monitor
bind usart_sync_slave usart_sync_slave_monitor u_usart_sync_slave_monitor (.*);
`default_nettype wire

// ===== usart_sync_slave_pkg.sv
// Operation
// - Slave never drives the shift clock; the external master supplies it on the clock pin.
// - Slave mode is active while clock source select (control bit 7) is clear.
// - External clock lets transmit and receive proceed while the core sleeps.
// - With two words queued, first goes to shifter, second waits, empty flag stays clear.
// - After first word shifts out, second moves to shifter, then empty flag sets.
// - Empty flag with transmit irq enable wakes core; with global enable, vector 0004h.
// - Ninth-bit enable makes each transmitted word nine bits, ninth from ninth value.
// - Transmit enable gates sending; a holding-register write starts the transfer.
// - Single-receive enable is ignored in slave mode.
// - Continuous receive enabled before sleep allows a full word to arrive in sleep.
// - A completed word moves from the receive shifter into the receive holding register.
// - Completed reception with receive irq enable wakes core; with global enable, vector 0004h.
// - Receive-full flag sets on completion; interrupt only when receive irq enable set.
// - Receive ninth-bit enable makes each received word nine bits.
// - Ninth bit and errors shown as status, eight data bits in holding register.
// - Clearing continuous receive enable clears pending receive errors.
// - Slave shifting follows master-mode timing apart from sleep behaviour.
package usart_sync_slave_pkg;

    // Word sizes
    localparam int unsigned WORD_BITS  = 8;
    localparam int unsigned LONG_BITS  = 9;
    localparam int unsigned CNT_W      = 4;

    // Bit counts per word
    localparam logic [CNT_W-1:0] BITS_SHORT = 4'h8;
    localparam logic [CNT_W-1:0] BITS_LONG  = 4'h9;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

    // Interrupt vector address
    localparam int unsigned     VEC_W       = 14;
    localparam logic [VEC_W-1:0] IRQ_VECTOR = 14'h0004;
    localparam logic [VEC_W-1:0] VEC_NONE   = 14'h0000;

    // Reset values
    localparam logic [WORD_BITS-1:0] DATA_RESET  = 8'h00;
    localparam logic [LONG_BITS-1:0] SHIFT_RESET = 9'h000;

    // Transmit shifter states
    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_e;

    // Bits per word for the ninth-bit option
    function automatic logic [CNT_W-1:0] wordLength(input logic ninth);
        wordLength = ninth ? BITS_LONG : BITS_SHORT;
    endfunction : wordLength

endpackage : usart_sync_slave_pkg
